/* design/l2rs_selector.sv */
// request event selector: qualifies cache request strobes and drives the counter increment
// ==========================================================================
`timescale 1ns/100ps
`include "l2rs_cfg.svh"

module l2rs_selector
   import l2rs_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // selection
   input wire logic [7:0] evt_num_i,
   input wire logic [7:0] unit_mask_i,
   // second level data load requests
   input wire logic l2_load_req_i,
   input wire logic l2_load_prefetch_i,
   input wire l2rs_mesi_t l2_load_state_i,
   // second level store ownership requests
   input wire logic l2_store_own_req_i,
   input wire logic l2_store_own_pf_i,
   input wire l2rs_mesi_t l2_store_own_state_i,
   // second level locked ownership requests
   input wire logic l2_locked_own_req_i,
   input wire l2rs_mesi_t l2_locked_own_state_i,
   // level1_data_cache writebacks to the second level
   input wire logic l1_writeback_req_i,
   input wire l2rs_mesi_t l1_writeback_state_i,
   // counter side
   output logic [1:0] cnt_inc_o,
   output logic cnt_inc_any_o,
   output logic sel_active_o,
   output l2rs_sel_t sel_kind_o,
   output logic store_pf_drop_o
);

   // ==========================================================================
   // stage one: sampled selection and strobes
   logic [7:0] evt_r;
   logic [7:0] evt_nxt;
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;
   logic load_req_r;
   logic load_req_nxt;
   logic load_pf_r;
   logic load_pf_nxt;
   l2rs_mesi_t load_st_r;
   l2rs_mesi_t load_st_nxt;
   logic store_req_r;
   logic store_req_nxt;
   logic store_pf_r;
   logic store_pf_nxt;
   l2rs_mesi_t store_st_r;
   l2rs_mesi_t store_st_nxt;
   logic lock_req_r;
   logic lock_req_nxt;
   l2rs_mesi_t lock_st_r;
   l2rs_mesi_t lock_st_nxt;
   logic wb_req_r;
   logic wb_req_nxt;
   l2rs_mesi_t wb_st_r;
   l2rs_mesi_t wb_st_nxt;

   // sampling every strobe with the selection keeps a count and its mask
   // from the same cycle, so a reprogram never mixes old strobes and new mask
   always_comb begin
      evt_nxt = evt_num_i;
      mask_nxt = unit_mask_i;
      load_req_nxt = l2_load_req_i;
      load_pf_nxt = l2_load_prefetch_i;
      load_st_nxt = l2_load_state_i;
      store_req_nxt = l2_store_own_req_i;
      store_pf_nxt = l2_store_own_pf_i;
      store_st_nxt = l2_store_own_state_i;
      lock_req_nxt = l2_locked_own_req_i;
      lock_st_nxt = l2_locked_own_state_i;
      wb_req_nxt = l1_writeback_req_i;
      wb_st_nxt = l1_writeback_state_i;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         evt_r <= 8'h00;
         mask_r <= 8'h00;
         load_req_r <= 1'b0;
         load_pf_r <= 1'b0;
         load_st_r <= L2RS_INVALID;
         store_req_r <= 1'b0;
         store_pf_r <= 1'b0;
         store_st_r <= L2RS_INVALID;
         lock_req_r <= 1'b0;
         lock_st_r <= L2RS_INVALID;
         wb_req_r <= 1'b0;
         wb_st_r <= L2RS_INVALID;
      end else begin
         evt_r <= evt_nxt;
         mask_r <= mask_nxt;
         load_req_r <= load_req_nxt;
         load_pf_r <= load_pf_nxt;
         load_st_r <= load_st_nxt;
         store_req_r <= store_req_nxt;
         store_pf_r <= store_pf_nxt;
         store_st_r <= store_st_nxt;
         lock_req_r <= lock_req_nxt;
         lock_st_r <= lock_st_nxt;
         wb_req_r <= wb_req_nxt;
         wb_st_r <= wb_st_nxt;
      end
   end

   // ==========================================================================
   // decode of the sampled selection
   logic [3:0] dem_en;
   logic [3:0] pf_en;
   logic [3:0] store_en;
   logic [3:0] lock_en;
   logic [3:0] wb_en;
   l2rs_sel_t kind;

   l2rs_event_decode u_decode (
      .evt_num_i(evt_r),
      .unit_mask_i(mask_r),
      .load_demand_en_o(dem_en),
      .load_prefetch_en_o(pf_en),
      .store_own_en_o(store_en),
      .locked_own_en_o(lock_en),
      .writeback_en_o(wb_en),
      .sel_kind_o(kind)
   );

   // ==========================================================================
   // per-class qualification
   logic dem_req;
   logic pf_req;
   logic store_req;
   logic dem_hit;
   logic pf_hit;
   logic store_hit;
   logic lock_hit;
   logic wb_hit;

   always_comb begin
      dem_req = load_req_r && !load_pf_r;
      pf_req = load_req_r && load_pf_r;
      store_req = store_req_r && !store_pf_r;
   end

   l2rs_state_match u_dem (
      .req_i(dem_req),
      .state_i(load_st_r),
      .state_en_i(dem_en),
      .hit_o(dem_hit)
   );

   l2rs_state_match u_pf (
      .req_i(pf_req),
      .state_i(load_st_r),
      .state_en_i(pf_en),
      .hit_o(pf_hit)
   );

   l2rs_state_match u_store (
      .req_i(store_req),
      .state_i(store_st_r),
      .state_en_i(store_en),
      .hit_o(store_hit)
   );

   l2rs_state_match u_lock (
      .req_i(lock_req_r),
      .state_i(lock_st_r),
      .state_en_i(lock_en),
      .hit_o(lock_hit)
   );

   l2rs_state_match u_wb (
      .req_i(wb_req_r),
      .state_i(wb_st_r),
      .state_en_i(wb_en),
      .hit_o(wb_hit)
   );

   // ==========================================================================
   // increment and status
   logic [1:0] inc_r;
   logic [1:0] inc_nxt;
   logic inc_any_r;
   logic inc_any_nxt;
   logic active_r;
   logic active_nxt;
   l2rs_sel_t kind_r;
   l2rs_sel_t kind_nxt;
   logic drop_r;
   logic drop_nxt;

   // one load strobe is either demand or prefetch, so at most two classes
   // (store and locked ownership) can land in one cycle; two bits suffice
   always_comb begin
      inc_nxt = 2'({1'b0, dem_hit | pf_hit | wb_hit})
         + 2'({1'b0, store_hit})
         + 2'({1'b0, lock_hit});
      inc_any_nxt = dem_hit | pf_hit | store_hit | lock_hit | wb_hit;
      active_nxt = (|dem_en) | (|pf_en) | (|store_en) | (|lock_en) | (|wb_en);
      kind_nxt = kind;
      // a prefetch-flagged ownership strobe breaks the partner's promise; flag it
      drop_nxt = store_req_r && store_pf_r;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         inc_r <= `L2RS_INC_RST;
         inc_any_r <= 1'b0;
         active_r <= 1'b0;
         kind_r <= L2RS_SEL_NONE;
         drop_r <= 1'b0;
      end else begin
         inc_r <= inc_nxt;
         inc_any_r <= inc_any_nxt;
         active_r <= active_nxt;
         kind_r <= kind_nxt;
         drop_r <= drop_nxt;
      end
   end

   always_comb begin
      cnt_inc_o = inc_r;
      cnt_inc_any_o = inc_any_r;
      sel_active_o = active_r;
      sel_kind_o = kind_r;
      store_pf_drop_o = drop_r;
   end

endmodule

/* design/l2rs_cfg.svh */
// event codes, unit mask fields, line state codes and pipeline figures of the request selector
`ifndef L2RS_CFG_SVH
`define L2RS_CFG_SVH

// ==========================================================================
// event numbers
`define L2RS_EVT_DATA_RQ 8'h26
`define L2RS_EVT_WRITE_OWN 8'h27
`define L2RS_EVT_L1_WB 8'h28

// ==========================================================================
// unit mask values that carry a name
`define L2RS_UM_PF_MODIFIED 8'h80
`define L2RS_UM_PF_ALL 8'hf0
`define L2RS_UM_DATA_ALL 8'hff
`define L2RS_UM_LO_INVALID 8'h01
`define L2RS_UM_LO_SHARED 8'h02
`define L2RS_UM_LO_EXCLUSIVE 8'h04
`define L2RS_UM_LO_MODIFIED 8'h08
`define L2RS_UM_LO_HIT 8'h0e
`define L2RS_UM_LO_ALL 8'h0f
`define L2RS_UM_HI_INVALID 8'h10
`define L2RS_UM_HI_SHARED 8'h20
`define L2RS_UM_HI_EXCLUSIVE 8'h40
`define L2RS_UM_HI_MODIFIED 8'h80
`define L2RS_UM_HI_HIT 8'he0
`define L2RS_UM_HI_ALL 8'hf0

// ==========================================================================
// unit mask field layout: one nibble per request class, one bit per line state
`define L2RS_NIB_LO_MSB 3
`define L2RS_NIB_LO_LSB 0
`define L2RS_NIB_HI_MSB 7
`define L2RS_NIB_HI_LSB 4

// ==========================================================================
// line state codes, equal to the bit index inside a nibble
`define L2RS_ST_INVALID 2'h0
`define L2RS_ST_SHARED 2'h1
`define L2RS_ST_EXCLUSIVE 2'h2
`define L2RS_ST_MODIFIED 2'h3

// ==========================================================================
// reset values and latency from strobe to increment, in core clock cycles
`define L2RS_INC_RST 2'h0
`define L2RS_LATENCY 2

`endif

/* design/l2rs_pkg.sv */
// types shared by the request selector modules
`include "l2rs_cfg.svh"

package l2rs_pkg;

   // ==========================================================================
   // line coherence state
   typedef enum logic [1:0] {
      L2RS_INVALID = 2'b00,
      L2RS_SHARED = 2'b01,
      L2RS_EXCLUSIVE = 2'b10,
      L2RS_MODIFIED = 2'b11
   } l2rs_mesi_t;

   // ==========================================================================
   // named selection currently programmed
   typedef enum logic [4:0] {
      L2RS_SEL_NONE = 5'b00000,
      L2RS_SEL_OTHER = 5'b00001,
      L2RS_L2_PREFETCH_LOAD_MODIFIED = 5'b00010,
      L2RS_L2_PREFETCH_LOAD_ALL = 5'b00011,
      L2RS_L2_DATA_REQUEST_ALL = 5'b00100,
      L2RS_L2_STORE_OWN_INVALID = 5'b00101,
      L2RS_L2_STORE_OWN_SHARED = 5'b00110,
      L2RS_L2_STORE_OWN_MODIFIED = 5'b00111,
      L2RS_L2_STORE_OWN_HIT = 5'b01000,
      L2RS_L2_STORE_OWN_ALL = 5'b01001,
      L2RS_L2_LOCKED_OWN_INVALID = 5'b01010,
      L2RS_L2_LOCKED_OWN_SHARED = 5'b01011,
      L2RS_L2_LOCKED_OWN_EXCLUSIVE = 5'b01100,
      L2RS_L2_LOCKED_OWN_MODIFIED = 5'b01101,
      L2RS_L2_LOCKED_OWN_HIT = 5'b01110,
      L2RS_L2_LOCKED_OWN_ALL = 5'b01111,
      L2RS_L1_WRITEBACK_INVALID = 5'b10000,
      L2RS_L1_WRITEBACK_SHARED = 5'b10001,
      L2RS_L1_WRITEBACK_EXCLUSIVE = 5'b10010,
      L2RS_L1_WRITEBACK_MODIFIED = 5'b10011,
      L2RS_L1_WRITEBACK_ALL = 5'b10100
   } l2rs_sel_t;

   // ==========================================================================
   // mask bit that enables a given line state inside one nibble
   function automatic logic l2rs_state_enabled(input logic [3:0] nib, input l2rs_mesi_t st);
      l2rs_state_enabled = nib[st];
   endfunction

endpackage

/* design/l2rs_state_match.sv */
// one request class: strobe qualified by line state against a unit mask nibble
`timescale 1ns/100ps

module l2rs_state_match
   import l2rs_pkg::*;
(
   // request
   input wire logic req_i,
   input wire l2rs_mesi_t state_i,
   // enabled states of this class
   input wire logic [3:0] state_en_i,
   // result
   output logic hit_o
);

   // ==========================================================================
   // qualification
   always_comb begin
      hit_o = req_i && l2rs_state_enabled(state_en_i, state_i);
   end

endmodule

/* design/l2rs_event_decode.sv */
// splits event number and unit mask into per-class state enables and a named selection
`timescale 1ns/100ps
`include "l2rs_cfg.svh"

module l2rs_event_decode
   import l2rs_pkg::*;
(
   // selection
   input wire logic [7:0] evt_num_i,
   input wire logic [7:0] unit_mask_i,
   // per-class state enables
   output logic [3:0] load_demand_en_o,
   output logic [3:0] load_prefetch_en_o,
   output logic [3:0] store_own_en_o,
   output logic [3:0] locked_own_en_o,
   output logic [3:0] writeback_en_o,
   // named selection
   output l2rs_sel_t sel_kind_o
);

   logic [3:0] lo_nib;
   logic [3:0] hi_nib;

   // ==========================================================================
   // enables
   always_comb begin
      lo_nib = unit_mask_i[`L2RS_NIB_LO_MSB:`L2RS_NIB_LO_LSB];
      hi_nib = unit_mask_i[`L2RS_NIB_HI_MSB:`L2RS_NIB_HI_LSB];
      load_demand_en_o = 4'h0;
      load_prefetch_en_o = 4'h0;
      store_own_en_o = 4'h0;
      locked_own_en_o = 4'h0;
      writeback_en_o = 4'h0;
      // unknown events enable nothing
      unique case (evt_num_i)
         `L2RS_EVT_DATA_RQ: begin
            load_demand_en_o = lo_nib;
            load_prefetch_en_o = hi_nib;
         end
         `L2RS_EVT_WRITE_OWN: begin
            store_own_en_o = lo_nib;
            locked_own_en_o = hi_nib;
         end
         `L2RS_EVT_L1_WB: begin
            // upper nibble has no class under this event
            writeback_en_o = lo_nib;
         end
         default: begin
         end
      endcase
   end

   // ==========================================================================
   // named selection
   always_comb begin
      sel_kind_o = L2RS_SEL_NONE;
      unique case (evt_num_i)
         `L2RS_EVT_DATA_RQ: begin
            unique case (unit_mask_i)
               `L2RS_UM_PF_MODIFIED: sel_kind_o = L2RS_L2_PREFETCH_LOAD_MODIFIED;
               `L2RS_UM_PF_ALL: sel_kind_o = L2RS_L2_PREFETCH_LOAD_ALL;
               `L2RS_UM_DATA_ALL: sel_kind_o = L2RS_L2_DATA_REQUEST_ALL;
               8'h00: sel_kind_o = L2RS_SEL_NONE;
               default: sel_kind_o = L2RS_SEL_OTHER;
            endcase
         end
         `L2RS_EVT_WRITE_OWN: begin
            unique case (unit_mask_i)
               `L2RS_UM_LO_INVALID: sel_kind_o = L2RS_L2_STORE_OWN_INVALID;
               `L2RS_UM_LO_SHARED: sel_kind_o = L2RS_L2_STORE_OWN_SHARED;
               `L2RS_UM_LO_MODIFIED: sel_kind_o = L2RS_L2_STORE_OWN_MODIFIED;
               `L2RS_UM_LO_HIT: sel_kind_o = L2RS_L2_STORE_OWN_HIT;
               `L2RS_UM_LO_ALL: sel_kind_o = L2RS_L2_STORE_OWN_ALL;
               `L2RS_UM_HI_INVALID: sel_kind_o = L2RS_L2_LOCKED_OWN_INVALID;
               `L2RS_UM_HI_SHARED: sel_kind_o = L2RS_L2_LOCKED_OWN_SHARED;
               `L2RS_UM_HI_EXCLUSIVE: sel_kind_o = L2RS_L2_LOCKED_OWN_EXCLUSIVE;
               `L2RS_UM_HI_MODIFIED: sel_kind_o = L2RS_L2_LOCKED_OWN_MODIFIED;
               `L2RS_UM_HI_HIT: sel_kind_o = L2RS_L2_LOCKED_OWN_HIT;
               `L2RS_UM_HI_ALL: sel_kind_o = L2RS_L2_LOCKED_OWN_ALL;
               8'h00: sel_kind_o = L2RS_SEL_NONE;
               default: sel_kind_o = L2RS_SEL_OTHER;
            endcase
         end
         `L2RS_EVT_L1_WB: begin
            unique case (unit_mask_i[`L2RS_NIB_LO_MSB:`L2RS_NIB_LO_LSB])
               4'h1: sel_kind_o = L2RS_L1_WRITEBACK_INVALID;
               4'h2: sel_kind_o = L2RS_L1_WRITEBACK_SHARED;
               4'h4: sel_kind_o = L2RS_L1_WRITEBACK_EXCLUSIVE;
               4'h8: sel_kind_o = L2RS_L1_WRITEBACK_MODIFIED;
               4'hf: sel_kind_o = L2RS_L1_WRITEBACK_ALL;
               4'h0: sel_kind_o = L2RS_SEL_NONE;
               default: sel_kind_o = L2RS_SEL_OTHER;
            endcase
         end
         default: sel_kind_o = L2RS_SEL_NONE;
      endcase
   end

endmodule

/* tb/l2rs_selector_assertions.sv */
// concurrent checks on the request selector ports
`timescale 1ns/100ps

// ==========================================================================
// checker
module l2rs_selector_checker
   import l2rs_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // selection and requests
   input wire logic [7:0] evt_num_i,
   input wire logic [7:0] unit_mask_i,
   input wire logic l2_load_req_i,
   input wire logic l2_load_prefetch_i,
   input wire l2rs_mesi_t l2_load_state_i,
   input wire logic l2_store_own_req_i,
   input wire logic l2_store_own_pf_i,
   input wire l2rs_mesi_t l2_store_own_state_i,
   input wire logic l2_locked_own_req_i,
   input wire l2rs_mesi_t l2_locked_own_state_i,
   input wire logic l1_writeback_req_i,
   input wire l2rs_mesi_t l1_writeback_state_i,
   // counter side
   input wire logic [1:0] cnt_inc_o,
   input wire logic cnt_inc_any_o,
   input wire logic sel_active_o,
   input wire l2rs_sel_t sel_kind_o,
   input wire logic store_pf_drop_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   // mask bit picked by the writeback's line state, so $past sees a plain signal
   logic wb_mask_bit;
   assign wb_mask_bit = unit_mask_i[l1_writeback_state_i];

   // ==========================================================================
   // request steps: selection and strobe sampled on one edge
   sequence ld26(logic [7:0] m);
      evt_num_i == 8'h26 && unit_mask_i == m && l2_load_req_i;
   endsequence
   sequence so27(logic [7:0] m);
      evt_num_i == 8'h27 && unit_mask_i == m && l2_store_own_req_i;
   endsequence
   sequence lk27(logic [7:0] m);
      evt_num_i == 8'h27 && unit_mask_i == m && l2_locked_own_req_i;
   endsequence

   quiet_event_a: assert property (!(evt_num_i inside {8'h26, 8'h27, 8'h28})
      |-> ##2 cnt_inc_o == 2'h0) else $error("count under unknown event");
   pf_modified_a: assert property (ld26(8'h80) |-> ##2 cnt_inc_o == {1'b0,
      $past(l2_load_prefetch_i, 2) && $past(l2_load_state_i, 2) == L2RS_MODIFIED})
      else $error("prefetch modified count wrong");
   pf_all_a: assert property (ld26(8'hf0) |-> ##2 cnt_inc_o == {1'b0,
      $past(l2_load_prefetch_i, 2)}) else $error("prefetch count wrong");
   data_any_a: assert property (ld26(8'hff) |-> ##2 cnt_inc_o == 2'h1)
      else $error("data request count wrong");
   store_hit_a: assert property (so27(8'h0e) |-> ##2 cnt_inc_o == {1'b0,
      !$past(l2_store_own_pf_i, 2) && $past(l2_store_own_state_i, 2) != L2RS_INVALID})
      else $error("store hit count wrong");
   store_all_a: assert property (so27(8'h0f) |-> ##2 cnt_inc_o == {1'b0,
      !$past(l2_store_own_pf_i, 2)}) else $error("store count wrong");
   locked_hit_a: assert property (lk27(8'he0) |-> ##2 cnt_inc_o == {1'b0,
      $past(l2_locked_own_state_i, 2) != L2RS_INVALID}) else $error("locked hit wrong");
   locked_all_a: assert property (lk27(8'hf0) |-> ##2 cnt_inc_o == 2'h1)
      else $error("locked count wrong");
   wb_state_a: assert property (evt_num_i == 8'h28 && l1_writeback_req_i
      |-> ##2 cnt_inc_o == {1'b0, $past(wb_mask_bit, 2)})
      else $error("writeback count wrong");
   pair_two_a: assert property (so27(8'hff) and lk27(8'hff)
      |-> ##2 cnt_inc_o == {!$past(l2_store_own_pf_i, 2), $past(l2_store_own_pf_i, 2)})
      else $error("paired count wrong");
   idle_zero_a: assert property (!(l2_load_req_i || l2_store_own_req_i
      || l2_locked_own_req_i || l1_writeback_req_i) |-> ##2 cnt_inc_o == 2'h0)
      else $error("count without strobe");
   any_flag_a: assert property (cnt_inc_any_o == (cnt_inc_o != 2'h0))
      else $error("increment flag disagrees");
endmodule

bind l2rs_selector l2rs_selector_checker chk (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .evt_num_i(evt_num_i),
   .unit_mask_i(unit_mask_i), .l2_load_req_i(l2_load_req_i),
   .l2_load_prefetch_i(l2_load_prefetch_i), .l2_load_state_i(l2_load_state_i),
   .l2_store_own_req_i(l2_store_own_req_i), .l2_store_own_pf_i(l2_store_own_pf_i),
   .l2_store_own_state_i(l2_store_own_state_i),
   .l2_locked_own_req_i(l2_locked_own_req_i),
   .l2_locked_own_state_i(l2_locked_own_state_i),
   .l1_writeback_req_i(l1_writeback_req_i),
   .l1_writeback_state_i(l1_writeback_state_i), .cnt_inc_o(cnt_inc_o),
   .cnt_inc_any_o(cnt_inc_any_o), .sel_active_o(sel_active_o),
   .sel_kind_o(sel_kind_o), .store_pf_drop_o(store_pf_drop_o)
);

/* tb/l2rs_cache_model.sv */
// cache controller model: turns a bench command word into registered request strobes
`timescale 1ns/100ps

// ==========================================================================
// word: ld pf st[2] | so pf st[2] | lk st[2] | wb st[2]
module l2rs_cache_model (
   // clock, reset and command
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [13:0] cmd_i,
   // request strobes toward the selector
   output logic [13:0] rq_o
);
   logic [13:0] rq_r;
   logic [13:0] rq_nxt;
   logic [1:0] pat_r;
   logic [1:0] pat_nxt;

   // states of idle classes walk every cycle so a stale state never looks valid
   always_comb begin
      pat_nxt = pat_r + 2'h1;
      rq_nxt = cmd_i;
      // demand ownership only; a prefetch flag appears solely when the bench asks
      rq_nxt[8] = cmd_i[9] & cmd_i[8];
      if (!cmd_i[13]) rq_nxt[11:10] = pat_r;
      if (!cmd_i[9]) rq_nxt[7:6] = ~pat_r;
      if (!cmd_i[5]) rq_nxt[4:3] = pat_r;
      if (!cmd_i[2]) rq_nxt[1:0] = ~pat_r;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rq_r <= 14'h0000;
         pat_r <= 2'h0;
      end else begin
         rq_r <= rq_nxt;
         pat_r <= pat_nxt;
      end
   end

   assign rq_o = rq_r;
endmodule

/* tb/test_l2rs_selector.sv */
// self-checking bench for the request event selector
`timescale 1ns/100ps

// ==========================================================================
// bench top
module test_l2rs_selector
   import l2rs_pkg::*;
;
   logic mclk_i;
   logic sys_rst_i;
   logic [7:0] ev;
   logic [7:0] um;
   logic [13:0] cmd;
   logic [13:0] rq;
   logic [1:0] inc;
   logic any;
   logic act;
   logic drop;
   l2rs_sel_t kind;
   int err_total;
   int checked;
   // four-state sums so an unknown increment shows up in the compare
   logic [31:0] sum;
   logic [31:0] drops;
   logic [31:0] anys;
   int cyc;

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   l2rs_cache_model ctl (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd), .rq_o(rq));

   l2rs_selector dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .evt_num_i(ev), .unit_mask_i(um),
      .l2_load_req_i(rq[13]), .l2_load_prefetch_i(rq[12]),
      .l2_load_state_i(l2rs_mesi_t'(rq[11:10])),
      .l2_store_own_req_i(rq[9]), .l2_store_own_pf_i(rq[8]),
      .l2_store_own_state_i(l2rs_mesi_t'(rq[7:6])),
      .l2_locked_own_req_i(rq[5]), .l2_locked_own_state_i(l2rs_mesi_t'(rq[4:3])),
      .l1_writeback_req_i(rq[2]), .l1_writeback_state_i(l2rs_mesi_t'(rq[1:0])),
      .cnt_inc_o(inc), .cnt_inc_any_o(any), .sel_active_o(act), .sel_kind_o(kind),
      .store_pf_drop_o(drop)
   );

   // ==========================================================================
   // counter side monitor and hang guard
   always @(negedge mclk_i) begin
      cyc++;
      if (!sys_rst_i) begin
         sum += inc;
         drops += drop;
         anys += any;
      end
      if (cyc == 5000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // every class strobes each cycle through all states, prefetch flags toggling
   task automatic run(input logic [7:0] e, input logic [7:0] m, input l2rs_sel_t k);
      int s0;
      int d0;
      int x;
      int xd;
      int xa;
      int v;
      int a0;
      logic [1:0] st;
      logic pf;
      logic sp;
      @(posedge mclk_i);
      ev <= e;
      um <= m;
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      s0 = sum;
      d0 = drops;
      a0 = anys;
      x = 0;
      xd = 0;
      xa = 0;
      for (int i = 0; i < 16; i++) begin
         st = i[1:0];
         pf = i[2];
         sp = i[3];
         v = 0;
         if (e == 8'h26) v = pf ? m[4 + st] : m[st];
         if (e == 8'h27) v = (!sp && m[st]) + m[4 + st];
         if (e == 8'h28) v = m[st];
         x += v;
         xa += (v != 0);
         if (e == 8'h27 && sp) xd++;
         @(posedge mclk_i);
         cmd <= {1'b1, pf, st, 1'b1, sp, st, 1'b1, st, 1'b1, st};
      end
      @(posedge mclk_i);
      cmd <= 14'h0000;
      repeat (6) @(posedge mclk_i);
      @(negedge mclk_i);
      check("count", 8'(sum - s0), 8'(x));
      check("any", 8'(anys - a0), 8'(xa));
      if (e == 8'h27) check("drops", 8'(drops - d0), 8'(xd));
      check("kind", {3'h0, kind}, {3'h0, k});
      check("active", {7'h00, act}, {7'h00, (e inside {8'h26, 8'h27} && m != 8'h00)
         || (e == 8'h28 && m[3:0] != 4'h0)});
   endtask

   task automatic t_load();
      run(8'h26, 8'h80, L2RS_L2_PREFETCH_LOAD_MODIFIED);
      run(8'h26, 8'hf0, L2RS_L2_PREFETCH_LOAD_ALL);
      run(8'h26, 8'hff, L2RS_L2_DATA_REQUEST_ALL);
      run(8'h26, 8'h21, L2RS_SEL_OTHER);
      $display("test load done");
   endtask

   task automatic t_store();
      run(8'h27, 8'h01, L2RS_L2_STORE_OWN_INVALID);
      run(8'h27, 8'h02, L2RS_L2_STORE_OWN_SHARED);
      run(8'h27, 8'h08, L2RS_L2_STORE_OWN_MODIFIED);
      run(8'h27, 8'h0e, L2RS_L2_STORE_OWN_HIT);
      run(8'h27, 8'h0f, L2RS_L2_STORE_OWN_ALL);
      $display("test store done");
   endtask

   task automatic t_locked();
      run(8'h27, 8'h10, L2RS_L2_LOCKED_OWN_INVALID);
      run(8'h27, 8'h20, L2RS_L2_LOCKED_OWN_SHARED);
      run(8'h27, 8'h40, L2RS_L2_LOCKED_OWN_EXCLUSIVE);
      run(8'h27, 8'h80, L2RS_L2_LOCKED_OWN_MODIFIED);
      run(8'h27, 8'he0, L2RS_L2_LOCKED_OWN_HIT);
      run(8'h27, 8'hf0, L2RS_L2_LOCKED_OWN_ALL);
      run(8'h27, 8'hff, L2RS_SEL_OTHER);
      $display("test locked done");
   endtask

   task automatic t_wb();
      run(8'h28, 8'h01, L2RS_L1_WRITEBACK_INVALID);
      run(8'h28, 8'h02, L2RS_L1_WRITEBACK_SHARED);
      run(8'h28, 8'h04, L2RS_L1_WRITEBACK_EXCLUSIVE);
      run(8'h28, 8'h08, L2RS_L1_WRITEBACK_MODIFIED);
      run(8'h28, 8'h0f, L2RS_L1_WRITEBACK_ALL);
      run(8'h28, 8'h03, L2RS_SEL_OTHER);
      $display("test writeback done");
   endtask

   // unmatched selections, then a reset landing in mid-burst
   task automatic t_none();
      run(8'h25, 8'hff, L2RS_SEL_NONE);
      run(8'h27, 8'h00, L2RS_SEL_NONE);
      @(posedge mclk_i);
      ev <= 8'h27;
      um <= 8'h0f;
      cmd <= 14'h0200;
      repeat (3) @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      @(negedge mclk_i);
      check("reset inc", {6'h00, inc}, 8'h00);
      check("reset kind", {3'h0, kind}, {3'h0, L2RS_SEL_NONE});
      @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      cmd <= 14'h0000;
      repeat (4) @(posedge mclk_i);
      $display("test none done");
   endtask

   task automatic complete_run();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      sys_rst_i = 1'b1;
      ev = 8'h00;
      um = 8'h00;
      cmd = 14'h0000;
      err_total = 0;
      checked = 0;
      sum = 0;
      drops = 0;
      anys = 0;
      cyc = 0;
      repeat (12) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_load();
      t_store();
      t_locked();
      t_wb();
      t_none();
      complete_run();
   end
endmodule
